// File: hw/asa_pkg.sv
package asa_pkg;

  // device-mode selector values
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL   = 2'h2;

  // commissioning presets
  localparam logic [5:0] PRESET_STD  = 6'h1E;  // 30: single, fixed speeds
  localparam logic [5:0] PRESET_DFIX = 6'h1F;  // 31: dual, fixed setpoints
  localparam logic [5:0] PRESET_MOD  = 6'h20;  // 32: single, modified
  localparam logic [5:0] PRESET_DCMD = 6'h22;  // 34: dual, on/off commands

  // address ranges (A: 0..31, B: 33..63 as 1B..31B)
  localparam logic [5:0] ADDR_ZERO  = 6'h00;
  localparam logic [5:0] ADDR_A_MAX = 6'h1F;
  localparam logic [5:0] ADDR_B_MIN = 6'h21;

  // indices of the address setting
  localparam int unsigned IDX_SUB1   = 0;
  localparam int unsigned IDX_SUB2   = 1;
  localparam int unsigned IDX_SINGLE = 1;

  // fixed-speed codes on the four output bits
  localparam logic [3:0] CODE_STOP = 4'h0;
  localparam logic [3:0] CODE_ACK  = 4'hF;

  // bit positions in the output nibble
  localparam int unsigned BIT_CW  = 0;
  localparam int unsigned BIT_CCW = 1;
  localparam int unsigned BIT_SRC = 2;
  localparam int unsigned BIT_ENA = 3;
  localparam int unsigned BIT_DIAG = 0;

  // slave profile nibbles
  localparam logic [3:0] PROF_IO     = 4'h7;
  localparam logic [3:0] PROF_ID_S   = 4'hF;
  localparam logic [3:0] PROF_ID2_S  = 4'hE;
  localparam logic [3:0] PROF_ID_D   = 4'hA;
  localparam logic [3:0] PROF_ID2_D  = 4'hE;

  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  // master request kinds
  typedef enum logic [1:0] {
    REQ_DATA   = 2'b00,
    REQ_PARAM  = 2'b01,
    REQ_ASSIGN = 2'b10,
    REQ_NONE   = 2'b11
  } asa_req_kind_t;

  typedef struct packed {
    logic          valid;
    asa_req_kind_t kind;
    logic [5:0]    addr;
    logic [3:0]    bits;      // output bits or parameter bits
    logic [5:0]    new_addr;  // address to assign
  } asa_req_t;

  typedef struct packed {
    logic       valid;
    logic       diag;         // bits carry a fault or alarm code
    logic [5:0] addr;
    logic [3:0] bits;
  } asa_rsp_t;

  typedef struct packed {
    logic       op_enable;
    logic       pulses_enabled;
    logic       ready_on;
    logic       ctrl_priority;
    logic       fault_pending;
    logic [3:0] fault_code;
  } asa_drv_status_t;

  typedef struct packed {
    logic [3:0] fixed_speed_sel;  // bit0..bit3 selection
    logic       ramp_stop;
    logic       coast_stop;
    logic       run_cw_command;
    logic       run_ccw_command;
    logic       speed_source_select;
    logic       operating_enable;
    logic       fault_ack_edge;
  } asa_drv_cmd_t;

  typedef struct packed {
    logic [3:0] io;
    logic [3:0] id;
    logic [3:0] id2;
  } asa_profile_t;

endpackage : asa_pkg

// File: hw/asa_in_sync.sv
`timescale 1ns/10ps
// three-stage pin synchroniser; output moves only when stages two and
// three agree, which rejects a single-cycle glitch after metastability
module asa_in_sync #(
  parameter bit RESET_VAL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic arst_n,
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic agree;

  assign agree = (s2_reg == s3_reg);

  // shift chain; s1 is read by s2 only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg    <= RESET_VAL;
      s2_reg    <= RESET_VAL;
      s3_reg    <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level_out <= s3_reg;
      end
    end
  end

endmodule : asa_in_sync

// File: hw/asa_slave.sv
`timescale 1ns/10ps
// How it works
// - addresses reset to zero; zero never exchanges
// - mode selector: 0 single (default), 2 dual
// - presets 30/32 load single, 31/34 dual
// - address and mode writes act at once
// - single slave at zero stores assigned address
// - dual: second hidden until first addressed
// - single uses index one, values 0..31
// - dual: index0 first, index1 second, A/B ranges
// - single: four data bits, diagnostics on P0
// - preset 30: D0..D3 drive fixed-speed bits
// - preset 30 reply: enable, pulses, local inputs
// - diagnostic request answers with pending fault code
// - preset 32: cw, ccw, source, ack/enable
// - preset 32 reply: ready, priority, local inputs
// - preset 32 sends a one-cycle message when a fault becomes pending
// - preset 32: parameter write latches scaling, diagnoses
// - single presets report profile 7.F.E
// - dual: eight data bits over two sub-slaves
// - code 0 ramp stop, 1..14 speeds, 15 ack
module asa_slave
  import asa_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               arst_n,
  input  wire asa_pkg::asa_req_t  mreq,
  output asa_pkg::asa_rsp_t       rsp,
  input  wire logic               preset_load,
  input  wire logic [5:0]         preset_code,
  input  wire logic               mode_write,
  input  wire logic [1:0]         mode_wdata,
  input  wire logic               addr_write,
  input  wire logic               addr_windex,
  input  wire logic [5:0]         addr_wdata,
  input  wire asa_pkg::asa_drv_status_t drv_status,
  input  wire logic               local_input_0,
  input  wire logic               local_input_1,
  output asa_pkg::asa_drv_cmd_t   drv_cmd,
  output logic [3:0]              scaling_factor,
  output logic [7:0]              dual_out_bits,
  output logic [1:0]              device_mode_select,
  output logic [5:0]              slave_address_setting_0,
  output logic [5:0]              slave_address_setting_1,
  output logic                    sub2_visible,
  output logic                    fault_msg_valid,
  output logic [3:0]              fault_msg_code,
  output asa_pkg::asa_profile_t   slave_profile
);
  import asa_pkg::*;

  logic [1:0]   mode_reg;
  logic [5:0]   preset_reg;
  logic [5:0]   addr_reg [2];
  logic [3:0]   dout_reg;
  logic [3:0]   scale_reg;
  logic [7:0]   dual_reg;
  logic         fpend_reg;
  asa_drv_cmd_t cmd_reg;
  asa_drv_cmd_t cmd_next;
  asa_rsp_t     rsp_reg;
  asa_rsp_t     rsp_next;
  logic         msg_reg;
  logic [3:0]   msg_code_reg;
  logic         loc0;
  logic         loc1;

  // local inputs come from pins
  asa_in_sync u_sync0 (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .pin_in    (local_input_0),
    .level_out (loc0)
  );
  asa_in_sync u_sync1 (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .pin_in    (local_input_1),
    .level_out (loc1)
  );

  // mode and preset decode
  wire is_dual    = (mode_reg == MODE_DUAL);
  wire preset_mod = (preset_reg == PRESET_MOD);
  wire pl_single  = (preset_code == PRESET_STD) ||
                    (preset_code == PRESET_MOD);
  wire pl_dual    = (preset_code == PRESET_DFIX) ||
                    (preset_code == PRESET_DCMD);
  wire mode_ok    = (mode_wdata == MODE_SINGLE) ||
                    (mode_wdata == MODE_DUAL);

  // address range checks, single allows A only
  wire wr_in_a    = (addr_wdata <= ADDR_A_MAX);
  wire wr_in_b    = (addr_wdata >= ADDR_B_MIN);
  wire wr_ok      = is_dual ? (wr_in_a || wr_in_b)
                            : (wr_in_a && addr_windex);
  wire new_in_a   = (mreq.new_addr <= ADDR_A_MAX);
  wire new_in_b   = (mreq.new_addr >= ADDR_B_MIN);
  wire new_ok     = is_dual ? (new_in_a || new_in_b) : new_in_a;

  // address match; second sub-slave hidden while both are zero
  wire both_zero  = (addr_reg[IDX_SUB1] == ADDR_ZERO) &&
                    (addr_reg[IDX_SUB2] == ADDR_ZERO);
  wire vis2       = !both_zero;
  wire hit_single = !is_dual && mreq.valid &&
                    (mreq.addr == addr_reg[IDX_SINGLE]);
  wire hit_sub1   = is_dual && mreq.valid &&
                    (mreq.addr == addr_reg[IDX_SUB1]);
  wire hit_sub2   = is_dual && mreq.valid && vis2 && !hit_sub1 &&
                    (mreq.addr == addr_reg[IDX_SUB2]);
  wire hit_any    = hit_single || hit_sub1 || hit_sub2;
  wire at_zero    = (mreq.addr == ADDR_ZERO);

  // cyclic exchange never runs at address zero
  wire data_take  = hit_any && !at_zero &&
                    (mreq.kind == REQ_DATA);
  wire parm_take  = hit_any && !at_zero &&
                    (mreq.kind == REQ_PARAM);
  wire asg_take   = hit_any && at_zero && new_ok &&
                    (mreq.kind == REQ_ASSIGN);
  wire asg_idx1   = hit_single || hit_sub2;
  wire sdata      = data_take && !is_dual;

  // software address write beats a master assignment in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_reg[IDX_SUB1] <= ADDR_ZERO;
      addr_reg[IDX_SUB2] <= ADDR_ZERO;
    end else if (addr_write && wr_ok) begin
      addr_reg[addr_windex] <= addr_wdata;
    end else if (asg_take) begin
      addr_reg[asg_idx1] <= mreq.new_addr;
    end
  end

  // mode selector; direct write wins over a preset in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg   <= MODE_SINGLE;
      preset_reg <= PRESET_STD;
    end else begin
      if (mode_write && mode_ok) begin
        mode_reg <= mode_wdata;
      end else if (preset_load && pl_single) begin
        mode_reg <= MODE_SINGLE;
      end else if (preset_load && pl_dual) begin
        mode_reg <= MODE_DUAL;
      end
      if (preset_load && (pl_single || pl_dual)) begin
        preset_reg <= preset_code;
      end
    end
  end

  // drive command decode from the newly accepted output nibble
  wire [3:0] d_new   = mreq.bits;
  wire       d3_rise = sdata && d_new[BIT_ENA] && !dout_reg[BIT_ENA];
  wire       to_ack  = sdata && (d_new == CODE_ACK) &&
                       (dout_reg != CODE_ACK);
  always_comb begin
    cmd_next = cmd_reg;
    cmd_next.fault_ack_edge = 1'b0;
    if (sdata && !preset_mod) begin
      cmd_next.fixed_speed_sel     = d_new;
      cmd_next.ramp_stop           = (d_new == CODE_STOP);
      cmd_next.coast_stop          = (d_new == CODE_ACK);
      cmd_next.fault_ack_edge      = to_ack;
      cmd_next.run_cw_command      = 1'b0;
      cmd_next.run_ccw_command     = 1'b0;
      cmd_next.speed_source_select = 1'b0;
      cmd_next.operating_enable    = 1'b0;
    end else if (sdata) begin
      cmd_next.fixed_speed_sel     = NIBBLE_ZERO;
      cmd_next.ramp_stop           = !d_new[BIT_CW] && !d_new[BIT_CCW];
      cmd_next.coast_stop          = 1'b0;
      cmd_next.run_cw_command      = d_new[BIT_CW];
      cmd_next.run_ccw_command     = d_new[BIT_CCW];
      cmd_next.speed_source_select = d_new[BIT_SRC];
      cmd_next.operating_enable    = d_new[BIT_ENA];
      cmd_next.fault_ack_edge      = d3_rise;
    end
  end

  // reply nibbles for each personality
  wire [3:0] rep_std = {loc1, loc0, drv_status.pulses_enabled,
                        drv_status.op_enable};
  wire [3:0] rep_mod = {loc1, loc0, drv_status.ctrl_priority,
                        drv_status.ready_on};
  wire [3:0] rep_dat = is_dual ? (hit_sub2 ? rep_std : NIBBLE_ZERO)
                               : (preset_mod ? rep_mod : rep_std);
  // under preset 32 every parameter write doubles as a diagnostic request
  wire       diag_rq = parm_take &&
                       (mreq.bits[BIT_DIAG] || preset_mod);

  // one reply per accepted data or parameter request, one cycle later
  always_comb begin
    rsp_next       = '0;
    rsp_next.valid = data_take || parm_take;
    rsp_next.addr  = mreq.addr;
    rsp_next.diag  = diag_rq;
    if (diag_rq) begin
      rsp_next.bits = drv_status.fault_code;
    end else if (parm_take) begin
      rsp_next.bits = mreq.bits;
    end else begin
      rsp_next.bits = rep_dat;
    end
  end

  // data paths, scaling latch and unsolicited fault message
  wire fault_rise = drv_status.fault_pending && !fpend_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_reg     <= NIBBLE_ZERO;
      scale_reg    <= NIBBLE_ZERO;
      dual_reg     <= '0;
      fpend_reg    <= 1'b0;
      cmd_reg      <= '0;
      rsp_reg      <= '0;
      msg_reg      <= 1'b0;
      msg_code_reg <= NIBBLE_ZERO;
    end else begin
      cmd_reg   <= cmd_next;
      rsp_reg   <= rsp_next;
      fpend_reg <= drv_status.fault_pending;
      msg_reg   <= fault_rise && preset_mod && !is_dual;
      if (fault_rise) begin
        msg_code_reg <= drv_status.fault_code;
      end
      if (sdata) begin
        dout_reg <= d_new;
      end
      if (parm_take && preset_mod && !is_dual) begin
        scale_reg <= mreq.bits;
      end
      if (data_take && hit_sub1) begin
        dual_reg[3:0] <= d_new;
      end
      if (data_take && hit_sub2) begin
        dual_reg[7:4] <= d_new;
      end
    end
  end

  // outputs
  assign rsp                     = rsp_reg;
  assign drv_cmd                 = cmd_reg;
  assign scaling_factor          = scale_reg;
  assign dual_out_bits           = dual_reg;
  assign device_mode_select      = mode_reg;
  assign slave_address_setting_0 = addr_reg[IDX_SUB1];
  assign slave_address_setting_1 = addr_reg[IDX_SUB2];
  assign sub2_visible            = is_dual && vis2;
  assign fault_msg_valid         = msg_reg;
  assign fault_msg_code          = msg_code_reg;
  assign slave_profile.io        = PROF_IO;
  assign slave_profile.id        = is_dual ? PROF_ID_D : PROF_ID_S;
  assign slave_profile.id2       = is_dual ? PROF_ID2_D : PROF_ID2_S;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_ZERO_NO_DATA: assert property (
    mreq.valid && at_zero && (mreq.kind == REQ_DATA) |=> !rsp.valid)
    else $error("reply given at address zero");
  AST_PRESET_MODE: assert property (
    preset_load && pl_dual && !mode_write |=> device_mode_select == MODE_DUAL)
    else $error("dual preset did not set dual mode");
  AST_MODE_NOW: assert property (
    mode_write && mode_ok |=> device_mode_select == $past(mode_wdata))
    else $error("mode write not effective");
  AST_ASSIGN_SINGLE: assert property (
    !is_dual && asg_take && !addr_write |=>
      slave_address_setting_1 == $past(mreq.new_addr))
    else $error("assigned address not stored");
  AST_SUB2_HIDDEN: assert property (
    is_dual && both_zero && !addr_write |=>
      slave_address_setting_1 == ADDR_ZERO)
    else $error("second sub-slave answered while hidden");
  AST_SINGLE_RANGE: assert property (
    !is_dual && addr_write && (addr_wdata > ADDR_A_MAX) && !asg_take
      |=> $stable(slave_address_setting_1))
    else $error("out-of-range single address accepted");
  AST_FIXED_SPEED: assert property (
    sdata && !preset_mod |=> drv_cmd.fixed_speed_sel == $past(mreq.bits))
    else $error("fixed speed bits not driven");
  AST_REPLY_STD: assert property (
    sdata && !preset_mod |=> rsp.valid && !rsp.diag &&
      rsp.bits[0] == $past(drv_status.op_enable))
    else $error("standard reply wrong");
  AST_DIAG: assert property (
    parm_take && mreq.bits[BIT_DIAG] |=> rsp.diag &&
      rsp.bits == $past(drv_status.fault_code))
    else $error("diagnostic reply wrong");
  AST_ACK_EDGE: assert property (
    drv_cmd.fault_ack_edge |=> !drv_cmd.fault_ack_edge)
    else $error("acknowledge pulse longer than one cycle");
  AST_SCALE: assert property (
    parm_take && preset_mod && !is_dual |=> rsp.diag &&
      scaling_factor == $past(mreq.bits))
    else $error("scaling factor not latched");

  COV_ASSIGN: cover property (asg_take);
  COV_DUAL_SUB2: cover property (data_take && hit_sub2);
  COV_MOD_ACK: cover property (preset_mod && d3_rise);

endmodule : asa_slave

// File: testbench/asa_master_model.sv
`timescale 1ns/10ps
// behavioural fieldbus master: one request per call, launched on the
// falling edge, released a cycle later; the one-cycle answer is read
// at that same falling edge, while it still stands
module asa_master_model #(
  parameter int unsigned N_ZERO = 1  // slaves that sit at address zero
) (
  input  wire logic           sys_clk,
  output asa_pkg::asa_req_t   mreq,
  input  wire asa_pkg::asa_rsp_t rsp
);
  import asa_pkg::*;

  logic [63:0] used;

  // zero is never handed out, so it starts marked
  initial begin
    used = 64'h1;
    mreq = '{1'b0, REQ_NONE, 6'h00, 4'h0, 6'h00};
  end

  // released fields go to the inverse so stale values never look valid
  task automatic request(input asa_req_kind_t k, input logic [5:0] a,
                         input logic [3:0] b, input logic [5:0] na,
                         output asa_rsp_t r);
    @(negedge sys_clk);
    mreq <= '{1'b1, k, a, b, na};
    @(negedge sys_clk);
    mreq <= '{1'b0, REQ_NONE, ~a, ~b, ~na};
    r = rsp;  // reply is gone after the next rising edge
  endtask : request

  // automatic assignment of a slave found at address zero
  task automatic assign_addr(input logic [5:0] na);
    asa_rsp_t r;
    if (N_ZERO > 1) begin
      return;
    end
    if (used[na]) begin
      return;
    end
    used[na] = 1'b1;
    request(REQ_ASSIGN, 6'h00, 4'h0, na, r);
  endtask : assign_addr
endmodule : asa_master_model

// File: testbench/asa_slave_addr_and_bitmap_test.sv
`timescale 1ns/10ps
module asa_slave_addr_and_bitmap_test;
  import asa_pkg::*;

  logic            sys_clk;
  logic            arst_n;
  asa_req_t        mreq;
  asa_rsp_t        rsp;
  logic            preset_load;
  logic [5:0]      preset_code;
  logic            mode_write;
  logic [1:0]      mode_wdata;
  logic            addr_write;
  logic            addr_windex;
  logic [5:0]      addr_wdata;
  asa_drv_status_t drv_status;
  logic            local_input_0;
  logic            local_input_1;
  asa_drv_cmd_t    drv_cmd;
  logic [3:0]      scaling_factor;
  logic [7:0]      dual_out_bits;
  logic [1:0]      device_mode_select;
  logic [5:0]      slave_address_setting_0;
  logic [5:0]      slave_address_setting_1;
  logic            sub2_visible;
  logic            fault_msg_valid;
  logic [3:0]      fault_msg_code;
  asa_profile_t    slave_profile;
  int              bad_count;
  int              checked;
  asa_rsp_t        r;
  logic [5:0]      pc [4];

  asa_slave u_asa_slave (
    .sys_clk(sys_clk), .arst_n(arst_n), .mreq(mreq), .rsp(rsp),
    .preset_load(preset_load), .preset_code(preset_code),
    .mode_write(mode_write), .mode_wdata(mode_wdata),
    .addr_write(addr_write), .addr_windex(addr_windex),
    .addr_wdata(addr_wdata), .drv_status(drv_status),
    .local_input_0(local_input_0), .local_input_1(local_input_1),
    .drv_cmd(drv_cmd), .scaling_factor(scaling_factor),
    .dual_out_bits(dual_out_bits),
    .device_mode_select(device_mode_select),
    .slave_address_setting_0(slave_address_setting_0),
    .slave_address_setting_1(slave_address_setting_1),
    .sub2_visible(sub2_visible), .fault_msg_valid(fault_msg_valid),
    .fault_msg_code(fault_msg_code), .slave_profile(slave_profile)
  );

  asa_master_model u_asa_master_model (
    .sys_clk(sys_clk), .mreq(mreq), .rsp(rsp)
  );

  // 200 MHz
  always #2.5 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  // one strobe pulse: 0 preset, 1 mode, 2 address; value visible on return
  task automatic ctl(input int which, input logic [5:0] v, input logic ix);
    @(negedge sys_clk);
    preset_code = v;
    mode_wdata  = v[1:0];
    addr_wdata  = v;
    addr_windex = ix;
    preset_load = (which == 0);
    mode_write  = (which == 1);
    addr_write  = (which == 2);
    @(negedge sys_clk);
    preset_load = 1'b0;
    mode_write  = 1'b0;
    addr_write  = 1'b0;
  endtask : ctl

  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // the sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    stop_test();
  end

  initial begin
    int n;
    sys_clk = 1'b0;
    arst_n = 1'b0;
    {preset_load, mode_write, addr_write, addr_windex} = 4'h0;
    preset_code = 6'h00;
    mode_wdata = 2'h0;
    addr_wdata = 6'h00;
    drv_status = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h6};
    local_input_0 = 1'b0;
    local_input_1 = 1'b1;
    bad_count = 0;
    checked = 0;
    pc = '{6'h1F, 6'h22, 6'h1E, 6'h20};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (6) @(negedge sys_clk);  // let the input synchronisers fill
    check("mode", 12'(device_mode_select), 12'h0);
    check("addr", 12'({slave_address_setting_0, slave_address_setting_1}),
          12'h0);
    check("profile", slave_profile, 12'h7FE);
    u_asa_master_model.request(REQ_DATA, 6'h00, 4'h3, 6'h00, r);
    check("rsp_at_zero", 12'(r.valid), 12'h0);
    u_asa_master_model.assign_addr(6'h05);
    check("auto_addr", 12'(slave_address_setting_1), 12'h05);
    $display("test reset and addressing done");
    // every fixed-speed code, reply carries enable, pulses, inputs
    for (int c = 0; c < 16; c++) begin
      u_asa_master_model.request(REQ_DATA, 6'h05, c[3:0], 6'h00, r);
      check("speed_sel", 12'(drv_cmd.fixed_speed_sel), 12'(c));
      check("ramp", 12'(drv_cmd.ramp_stop), 12'(c == 0));
      check("coast", 12'(drv_cmd.coast_stop), 12'(c == 15));
      check("reply30", 12'({r.valid, r.bits}), 12'h19);
    end
    check("ack_on_f", 12'(drv_cmd.fault_ack_edge), 12'h1);
    u_asa_master_model.request(REQ_PARAM, 6'h05, 4'h1, 6'h00, r);
    check("diag", 12'({r.valid, r.diag, r.bits}), 12'h36);
    u_asa_master_model.request(REQ_PARAM, 6'h05, 4'h6, 6'h00, r);
    check("no_diag", 12'({r.valid, r.diag, r.bits}), 12'h26);
    $display("test standard personality done");
    // address setting limits in single mode
    ctl(2, 6'h20, 1'b1);
    check("addr_32", 12'(slave_address_setting_1), 12'h05);
    ctl(2, 6'h09, 1'b0);
    check("idx0", 12'(slave_address_setting_0), 12'h00);
    ctl(2, 6'h1F, 1'b1);
    check("addr_31", 12'(slave_address_setting_1), 12'h1F);
    ctl(1, 6'h03, 1'b0);
    check("mode_bad", 12'(device_mode_select), 12'h0);
    ctl(1, 6'h02, 1'b0);
    check("mode_dual", 12'(device_mode_select), 12'h2);
    for (int i = 0; i < 4; i++) begin
      ctl(0, pc[i], 1'b0);
      check("preset", 12'(device_mode_select),
            (i < 2) ? 12'h2 : 12'h0);
    end
    check("profile_s", slave_profile, 12'h7FE);
    $display("test settings done");
    // modified personality at address 31; D3 low first so 9 gives an edge
    u_asa_master_model.request(REQ_DATA, 6'h1F, 4'h2, 6'h00, r);
    check("cmd2", 12'({drv_cmd.run_ccw_command, drv_cmd.operating_enable,
          drv_cmd.ramp_stop}), 12'h4);
    u_asa_master_model.request(REQ_DATA, 6'h1F, 4'h9, 6'h00, r);
    check("cmd9", 12'({drv_cmd.run_cw_command, drv_cmd.run_ccw_command,
          drv_cmd.speed_source_select, drv_cmd.operating_enable,
          drv_cmd.fault_ack_edge}), 12'h13);
    check("reply32", 12'({r.valid, r.bits}), 12'h1A);
    u_asa_master_model.request(REQ_DATA, 6'h1F, 4'hE, 6'h00, r);
    check("cmdE", 12'({drv_cmd.run_cw_command, drv_cmd.run_ccw_command,
          drv_cmd.speed_source_select, drv_cmd.operating_enable,
          drv_cmd.fault_ack_edge}), 12'h0E);
    u_asa_master_model.request(REQ_PARAM, 6'h1F, 4'hA, 6'h00, r);
    check("scale", 12'({r.diag, r.bits, scaling_factor}),
          12'h16A);
    drv_status.fault_pending = 1'b1;
    n = 0;
    while (fault_msg_valid !== 1'b1 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    check("fault_msg", 12'({fault_msg_valid, fault_msg_code}),
          12'h16);
    @(negedge sys_clk);
    check("fault_pulse", 12'(fault_msg_valid), 12'h0);
    drv_status.fault_pending = 1'b0;
    $display("test modified personality done");
    // dual device: second sub-slave hidden until the first is addressed
    ctl(0, 6'h22, 1'b0);
    ctl(2, 6'h00, 1'b1);
    check("hidden", 12'(sub2_visible), 12'h0);
    check("profile_d", slave_profile, 12'h7AE);
    u_asa_master_model.assign_addr(6'h21);
    check("sub1", 12'({sub2_visible, slave_address_setting_0}),
          12'h61);
    u_asa_master_model.assign_addr(6'h07);
    check("sub2", 12'(slave_address_setting_1), 12'h07);
    u_asa_master_model.request(REQ_DATA, 6'h21, 4'h5, 6'h00, r);
    check("sub1_rsp", 12'({r.valid, r.bits}), 12'h10);
    u_asa_master_model.request(REQ_DATA, 6'h07, 4'hA, 6'h00, r);
    check("sub2_rsp", 12'({r.valid, r.bits}), 12'h19);
    check("dual_bits", 12'(dual_out_bits), 12'hA5);
    u_asa_master_model.request(REQ_PARAM, 6'h07, 4'h1, 6'h00, r);
    check("dual_diag", 12'({r.valid, r.diag, r.bits}), 12'h36);
    check("rsp_addr", 12'(r.addr), 12'h07);
    ctl(2, 6'h20, 1'b0);
    check("b_gap", 12'(slave_address_setting_0), 12'h21);
    $display("test dual device done");
    stop_test();
  end
endmodule : asa_slave_addr_and_bitmap_test
